// file: rtl/tcpe_pkg.sv
// Package for the Type-C PHY enable control block: register map, field
// positions, reset values, host speed codes and the carrier structs.
// Assumes an APB register bus with 32-bit data and byte addresses.
`default_nettype none

package tcpe_pkg;

   // Ports with a superspeed PHY pair
   localparam int unsigned TCPE_NPORT = 3;
   localparam int unsigned TCPE_AW = 8;

   // Register byte addresses
   localparam logic [TCPE_AW-1:0] TCPE_ADDR_CTRL = 8'h00;
   localparam logic [TCPE_AW-1:0] TCPE_ADDR_STAT = 8'h04;

   // Control register fields and reset value
   localparam int unsigned TCPE_CTRL_W = 2;
   localparam int unsigned TCPE_CTRL_PHY_ALLOW_BIT = 0;
   localparam int unsigned TCPE_CTRL_SUSP_EN_BIT = 1;
   localparam logic [TCPE_CTRL_W-1:0] TCPE_CTRL_RESET = 2'h3;

   // Status register fields
   localparam int unsigned TCPE_STAT_PHY_A_LSB = 0;
   localparam int unsigned TCPE_STAT_PHY_B_LSB = 4;
   localparam int unsigned TCPE_STAT_SCHEME_BIT = 8;
   localparam int unsigned TCPE_STAT_POL_BIT = 9;
   localparam int unsigned TCPE_STAT_HOST_CONN_BIT = 10;
   localparam int unsigned TCPE_STAT_HOST_SS_BIT = 11;
   localparam int unsigned TCPE_STAT_SUSP_BIT = 12;

   // Host speed indicator codes
   localparam logic [1:0] TCPE_HOST_TYPE_GEN1 = 2'h0;
   localparam logic [1:0] TCPE_HOST_TYPE_USB2 = 2'h1;

   // Attach and orientation pins, raw levels as seen at the pins
   typedef struct packed {
      logic [TCPE_NPORT-1:0] comb_attach_in;
      logic orientation_in;
      logic orient_a_attach_in;
      logic orient_b_attach_in;
   } tcpe_attach_t;

   // PHY power enables, one A and one B per port
   typedef struct packed {
      logic [TCPE_NPORT-1:0] a;
      logic [TCPE_NPORT-1:0] b;
   } tcpe_phy_en_t;

   // Upstream link state from the hub core
   typedef struct packed {
      logic connected;
      logic superspeed;
      logic usb2_suspend;
   } tcpe_host_t;

endpackage

`default_nettype wire

// file: rtl/tcpe_phy_enable.sv
// Type-C PHY enable control: powers the superspeed PHYs of each
// downstream port from attach and orientation pins, drives the host
// speed indicator and the suspend indicator, APB slave for control.
// Assumes pins are synchronous to clk_i and the hub core supplies the
// upstream link state.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`default_nettype none

module tcpe_phy_enable #(
   parameter int unsigned TC_PORT = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tcpe_pkg::TCPE_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Attach, orientation and strap pins
   input wire tcpe_pkg::tcpe_attach_t attach_i,
   input wire logic attach_polarity_sel_i,
   input wire logic control_scheme_sel_i,
   // Upstream link state from hub core
   input wire tcpe_pkg::tcpe_host_t host_i,
   // PHY power enables
   output tcpe_pkg::tcpe_phy_en_t phy_en_o,
   // Host speed indicator, tri-state pin as value and enable
   output logic [1:0] host_type_o,
   output logic host_type_oe_o,
   // Suspend indicator
   output logic suspend_ind_out_o
);

   localparam int unsigned NP = tcpe_pkg::TCPE_NPORT;

   // Pin level to logical assertion under the polarity select
   function automatic logic pin_active(input logic lvl, input logic pol);
      pin_active = lvl ^ pol;
   endfunction

   // Full-width compare of the bus address against one register offset
   function automatic logic reg_hit(
      input logic [tcpe_pkg::TCPE_AW-1:0] addr,
      input logic [tcpe_pkg::TCPE_AW-1:0] offs
   );
      reg_hit = (addr == offs);
   endfunction

   // Register state
   logic [tcpe_pkg::TCPE_CTRL_W-1:0] ctrl_q;
   logic [tcpe_pkg::TCPE_CTRL_W-1:0] ctrl_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   tcpe_pkg::tcpe_phy_en_t phy_en_q;
   tcpe_pkg::tcpe_phy_en_t phy_en_d;
   logic [1:0] host_type_q;
   logic [1:0] host_type_d;
   logic host_oe_q;
   logic host_oe_d;
   logic susp_q;
   logic susp_d;

   // Decoded inputs
   logic [NP-1:0] comb_act;
   logic orient_act;
   logic a_act;
   logic b_act;

   // Candidate enables of each scheme before the scheme select
   logic [NP-1:0] s1_a;
   logic [NP-1:0] s1_b;
   logic [NP-1:0] s2_a;
   logic [NP-1:0] s2_b;

   // Register bus decode
   logic phy_allow;
   logic setup;
   logic access;
   logic hit_ctrl;
   logic hit_stat;
   logic [31:0] stat_word;

   assign phy_allow = ctrl_q[tcpe_pkg::TCPE_CTRL_PHY_ALLOW_BIT];

   // Pin decode: one polarity select flips every attach and orientation pin
   always_comb begin
      for (int i = 0; i < NP; i++) begin
         comb_act[i] = pin_active(attach_i.comb_attach_in[i],
                                  attach_polarity_sel_i);
      end
      orient_act = pin_active(attach_i.orientation_in,
                              attach_polarity_sel_i);
      a_act = pin_active(attach_i.orient_a_attach_in,
                         attach_polarity_sel_i);
      b_act = pin_active(attach_i.orient_b_attach_in,
                         attach_polarity_sel_i);
   end

   // First scheme: combined attach per port, orientation on the Type-C port
   always_comb begin
      s1_a = '0;
      s1_b = '0;
      for (int i = 0; i < NP; i++) begin
         if (i == TC_PORT) begin
            s1_a[i] = comb_act[i] & ~orient_act;
            s1_b[i] = comb_act[i] & orient_act;
         end else begin
            s1_a[i] = comb_act[i];
         end
      end
   end

   // Second scheme: only the Type-C port is served, the rest stay down
   always_comb begin
      s2_a = '0;
      s2_b = '0;
      s2_a[TC_PORT] = a_act;
      s2_b[TC_PORT] = b_act;
   end

   // Scheme select; pins of the other scheme never reach the enables
   always_comb begin
      if (control_scheme_sel_i) begin
         phy_en_d.a = s2_a;
         phy_en_d.b = s2_b;
      end else begin
         phy_en_d.a = s1_a;
         phy_en_d.b = s1_b;
      end
      // Software may hold every PHY down, e.g. during bring-up
      if (!phy_allow) begin
         phy_en_d = '0;
      end
   end

   // Host speed indicator; the pin floats while no host is attached
   always_comb begin
      host_oe_d = host_i.connected;
      if (host_i.superspeed) begin
         host_type_d = tcpe_pkg::TCPE_HOST_TYPE_GEN1;
      end else begin
         host_type_d = tcpe_pkg::TCPE_HOST_TYPE_USB2;
      end
   end

   // Suspend only means USB 2.0 suspend, so a superspeed link masks it
   always_comb begin
      susp_d = host_i.connected & ~host_i.superspeed & host_i.usb2_suspend
             & ctrl_q[tcpe_pkg::TCPE_CTRL_SUSP_EN_BIT];
   end

   // PHY enables are registered so glitches on the pins never reach power
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         phy_en_q <= '0;
      end else begin
         phy_en_q <= phy_en_d;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         host_type_q <= tcpe_pkg::TCPE_HOST_TYPE_GEN1;
      end else begin
         host_type_q <= host_type_d;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         host_oe_q <= 1'b0;
      end else begin
         host_oe_q <= host_oe_d;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         susp_q <= 1'b0;
      end else begin
         susp_q <= susp_d;
      end
   end

   // APB slave: zero wait states, read data captured in the setup cycle.
   // Control word: bit 0 allows PHY power, bit 1 allows the suspend pin.
   // Status word: A enables, B enables, strap levels and host state.
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign hit_ctrl = reg_hit(paddr, tcpe_pkg::TCPE_ADDR_CTRL);
   assign hit_stat = reg_hit(paddr, tcpe_pkg::TCPE_ADDR_STAT);
   assign pready = 1'b1;

   // Error only in the access phase: unmapped, or a write to status
   always_comb begin
      pslverr = 1'b0;
      if (access) begin
         if (pwrite) begin
            pslverr = ~hit_ctrl;
         end else begin
            pslverr = ~(hit_ctrl | hit_stat);
         end
      end
   end

   always_comb begin
      stat_word = '0;
      stat_word[tcpe_pkg::TCPE_STAT_PHY_A_LSB +: NP] = phy_en_q.a;
      stat_word[tcpe_pkg::TCPE_STAT_PHY_B_LSB +: NP] = phy_en_q.b;
      stat_word[tcpe_pkg::TCPE_STAT_SCHEME_BIT] = control_scheme_sel_i;
      stat_word[tcpe_pkg::TCPE_STAT_POL_BIT] = attach_polarity_sel_i;
      stat_word[tcpe_pkg::TCPE_STAT_HOST_CONN_BIT] = host_oe_q;
      stat_word[tcpe_pkg::TCPE_STAT_HOST_SS_BIT] =
         host_oe_q & (host_type_q == tcpe_pkg::TCPE_HOST_TYPE_GEN1);
      stat_word[tcpe_pkg::TCPE_STAT_SUSP_BIT] = susp_q;
   end

   // Writes land only in the access phase, never in setup
   always_comb begin
      ctrl_d = ctrl_q;
      if (access && pwrite && hit_ctrl) begin
         ctrl_d = pwdata[tcpe_pkg::TCPE_CTRL_W-1:0];
      end
   end

   // Read data is held until the next read setup
   always_comb begin
      rdata_d = rdata_q;
      if (setup && !pwrite) begin
         if (hit_ctrl) begin
            rdata_d = {{(32-tcpe_pkg::TCPE_CTRL_W){1'b0}}, ctrl_q};
         end else if (hit_stat) begin
            rdata_d = stat_word;
         end else begin
            rdata_d = '0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_q <= tcpe_pkg::TCPE_CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Output ports

   assign prdata = rdata_q;
   assign phy_en_o = phy_en_q;
   assign host_type_o = host_type_q;
   assign host_type_oe_o = host_oe_q;
   assign suspend_ind_out_o = susp_q;

endmodule

`default_nettype wire

// file: verif/tcpe_checker.sv
// Assertions on the PHY enable block ports.
// Assumes CTRL holds its reset value 2'h3.
`default_nettype none
module tcpe_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Pins and outputs
   input wire tcpe_pkg::tcpe_attach_t attach_i,
   input wire logic attach_polarity_sel_i,
   input wire logic control_scheme_sel_i,
   input wire tcpe_pkg::tcpe_host_t host_i,
   input wire tcpe_pkg::tcpe_phy_en_t phy_en_o,
   input wire logic [1:0] host_type_o,
   input wire logic host_type_oe_o,
   input wire logic suspend_ind_out_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] a_d;
   logic [5:0] a_q;
   logic m_q;
   logic l_q;
   tcpe_pkg::tcpe_host_t h_q;
   tcpe_pkg::tcpe_phy_en_t p;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   always_comb a_d = attach_i ^ {6{attach_polarity_sel_i}};
   always_comb p = phy_en_o;
   // Outputs lag the pins by one edge
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         {l_q, m_q, a_q, h_q} <= '0;
      end else begin
         {l_q, m_q, a_q, h_q} <= {1'b1, control_scheme_sel_i, a_d, host_i};
      end
   end
   chk_m2_b: assert property (l_q && m_q |-> p.b[1] == a_q[0])
      else $error("orientation B enable wrong");
   chk_m2_a: assert property (l_q && m_q |-> p.a[1] == a_q[1])
      else $error("orientation A enable wrong");
   chk_m2_rest: assert property (l_q && m_q |->
      {p.a[2], p.a[0], p.b[2], p.b[0]} == 4'h0) else $error("stray enable");
   chk_m1_comb: assert property (l_q && !m_q |->
      {p.a[2], p.a[0]} == {a_q[5], a_q[3]}) else $error("attach enable wrong");
   chk_m1_orient: assert property (l_q && !m_q |->
      {p.a[1], p.b[1]} == {a_q[4] & !a_q[2], a_q[4] & a_q[2]})
      else $error("orientation select wrong");
   chk_host_speed: assert property (l_q && h_q.connected |->
      host_type_oe_o && host_type_o == (h_q.superspeed ?
      tcpe_pkg::TCPE_HOST_TYPE_GEN1 : tcpe_pkg::TCPE_HOST_TYPE_USB2))
      else $error("host speed wrong");
   chk_host_float: assert property (l_q && !h_q.connected |->
      !host_type_oe_o) else $error("host speed driven unconnected");
   chk_suspend_ind_out: assert property (l_q |-> suspend_ind_out_o ==
      (h_q.connected && !h_q.superspeed && h_q.usb2_suspend))
      else $error("suspend indicator wrong");
   cover property (l_q && m_q && p.b[1]);
   cover property (l_q && !m_q && p.b[1]);
   cover property (suspend_ind_out_o);
endmodule
bind tcpe_phy_enable tcpe_checker chk (.clk_i, .reset_i, .attach_i,
   .attach_polarity_sel_i, .control_scheme_sel_i, .host_i, .phy_en_o,
   .host_type_o, .host_type_oe_o, .suspend_ind_out_o);
`default_nettype wire

// file: verif/tcpe_cc_model.sv
// Port controller model driving the attach and scheme pins.
// Assumes the bench asks for active levels; pins are encoded here.
`default_nettype none
module tcpe_cc_model (
   // Clock
   input wire logic clk_i,
   // Requested levels, polarity, scheme, slow answer
   input wire logic [5:0] want_i,
   input wire logic pol_i,
   input wire logic scheme_i,
   input wire logic slow_i,
   // Pins toward the hub
   output tcpe_pkg::tcpe_attach_t attach_o,
   output logic scheme_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] pin_d;
   logic [5:0] junk_q = 6'h15;
   logic tick_q = 1'b0;
   initial {attach_o, scheme_o} = '0;
   always_comb begin
      pin_d = want_i ^ {6{pol_i}};
      // Pins of the idle scheme toggle while slow_i is low, so any leak shows
      if (scheme_i) pin_d[5:2] = junk_q[5:2];
      else pin_d[1:0] = junk_q[1:0];
   end
   always @(posedge clk_i) begin
      junk_q <= ~junk_q;
      tick_q <= ~tick_q;
      if (!slow_i || tick_q) begin
         attach_o <= pin_d;
         scheme_o <= scheme_i;
      end
   end
endmodule
`default_nettype wire

// file: verif/tcpe_phy_enable_tb_top.sv
// Bench for the PHY enable block: random pins, host state, APB.
// Assumes zero-wait APB and outputs one edge behind the pins.
`default_nettype none
module tcpe_phy_enable_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   tcpe_pkg::tcpe_attach_t att;
   tcpe_pkg::tcpe_host_t host = '0;
   tcpe_pkg::tcpe_phy_en_t en;
   logic [1:0] ht;
   logic hoe;
   logic susp;
   logic [9:0] obs;
   logic pol = 1'b0;
   logic sch = 1'b0;
   logic sch_pin;
   logic slow = 1'b0;
   logic look = 1'b0;
   logic [5:0] want = 6'h0;
   logic [9:0] exq[$];
   integer seed = 32'hb58977e1;
   int failures = 0;
   int tests_run = 0;
   assign obs = {en, hoe, ht & {2{hoe}}, susp};
   tcpe_phy_enable dut (.clk_i, .reset_i, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .attach_i(att),
      .attach_polarity_sel_i(pol), .control_scheme_sel_i(sch_pin),
      .host_i(host), .phy_en_o(en), .host_type_o(ht),
      .host_type_oe_o(hoe), .suspend_ind_out_o(susp));
   tcpe_cc_model cc (.clk_i, .want_i(want), .pol_i(pol), .scheme_i(sch),
      .slow_i(slow), .attach_o(att), .scheme_o(sch_pin));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Expected enables, host code and suspend for one random draw
   function automatic logic [9:0] expf(input logic [31:0] r);
      logic [2:0] a;
      logic [2:0] b;
      a = r[7] ? {1'b0, r[1], 1'b0} : {r[5], r[4] & !r[2], r[3]};
      b = {1'b0, r[7] ? r[0] : r[4] & r[2], 1'b0};
      return {a, b, r[11], r[11] ? (r[10] ? tcpe_pkg::TCPE_HOST_TYPE_GEN1 :
         tcpe_pkg::TCPE_HOST_TYPE_USB2) : 2'h0, r[11] & !r[10] & r[9]};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [31:0] ed, input logic ee);
      int n;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         summarize();
      end
      chk({31'h0, pslverr}, {31'h0, ee});
      if (!w) chk(prdata, ed);
      {psel, penable} <= 2'b00;
      @(posedge clk_i);
   endtask
   always @(posedge clk_i) begin
      if (look) chk(obs, exq.pop_front());
   end
   initial forever #2 clk_i = ~clk_i;
   initial begin
      logic [31:0] r;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 64; i++) begin
         r = $random(seed);
         {host, slow, sch, pol, want} <= r[11:0];
         repeat (5) @(posedge clk_i);
         exq.push_back(expf(r));
         look <= 1'b1;
         @(posedge clk_i);
         look <= 1'b0;
      end
      // Mid-run reset clears every output except pready, which stays high
      reset_i <= 1'b1;
      {host, sch, pol, want} <= {3'h0, 1'b1, 1'b0, 6'h0};
      @(negedge clk_i);
      chk(obs, 10'h0);
      @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      apb(1'b1, tcpe_pkg::TCPE_ADDR_CTRL, 32'h3, 32'h0, 1'b0);
      apb(1'b0, tcpe_pkg::TCPE_ADDR_CTRL, 32'h0, 32'h3, 1'b0);
      apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
      apb(1'b1, tcpe_pkg::TCPE_ADDR_STAT, 32'hffff, 32'h0, 1'b1);
      apb(1'b0, tcpe_pkg::TCPE_ADDR_STAT, 32'h0, 32'h100, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
